// ### rtl/slpr_consts.svh
// Offsets, field positions, reset values and fixed field contents of the link parameter bank
`ifndef SLPR_CONSTS_SVH
`define SLPR_CONSTS_SVH

// ==========================================================
// Register offsets
`define SLPR_ADDR_DESCRAMBLE_LANE_COUNT 12'h453
`define SLPR_ADDR_OCTETS_PER_FRAME      12'h454
`define SLPR_ADDR_FRAMES_PER_MULTIFRAME 12'h455
`define SLPR_ADDR_CONVERTERS_PER_DEVICE 12'h456
`define SLPR_ADDR_CONTROL_BITS_RES      12'h457
`define SLPR_ADDR_SUBCLASS_SAMPLE_WIDTH 12'h458
`define SLPR_ADDR_VERSION_SAMPLES       12'h459

// ==========================================================
// Field positions
`define SLPR_DESCRAMBLE_BIT             7
`define SLPR_UPPER_FIELD_MSB            7
`define SLPR_UPPER_FIELD_LSB            5
`define SLPR_LOW_FIELD_MSB              4

// ==========================================================
// Reset values of writable fields
`define SLPR_RST_DESCRAMBLE             1'h1
`define SLPR_RST_FRAMES_M1              5'h1F
`define SLPR_RST_SUBCLASS               3'h0
`define SLPR_RST_VERSION                3'h0

// ==========================================================
// Fixed read-only contents (counts minus one, except the control bit count, which is stored as is)
`define SLPR_LANE_COUNT_M1              5'h07
`define SLPR_OCTETS_M1                  8'h00
`define SLPR_CONVERTERS_M1              8'h01
`define SLPR_CONTROL_BITS               2'h0
`define SLPR_RESOLUTION_M1              5'h0F
`define SLPR_SAMPLE_BITS_M1             5'h0F
`define SLPR_SAMPLES_M1                 5'h01

// ==========================================================
// Codes of subclass and interface version
`define SLPR_SUBCLASS_0                 3'h0
`define SLPR_SUBCLASS_1                 3'h1
`define SLPR_VERSION_A                  3'h0
`define SLPR_VERSION_B                  3'h1

`endif

// ### rtl/slpr_pkg.sv
// Types shared by the link parameter bank
package slpr_pkg;
  // ==========================================================
  // Register bus types
  typedef logic [11:0] slpr_addr_t;
  typedef logic [7:0]  slpr_byte_t;
endpackage : slpr_pkg

// ### rtl/slpr_regs.sv
// Link parameter register bank of the serial lane receiver
`timescale 1ns/1ps
`include "slpr_consts.svh"

module slpr_regs (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Register port
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire slpr_pkg::slpr_addr_t reg_addr,
  input  wire slpr_pkg::slpr_byte_t reg_wdata,
  output logic                  reg_rvalid,
  output slpr_pkg::slpr_byte_t  reg_rdata,
  // Link core state
  input  wire logic             link_soft_reset,
  // Settings towards the link core
  output logic                  descramble_enable,
  output logic [4:0]            frames_per_multiframe_m1,
  output logic [2:0]            device_subclass,
  output logic [2:0]            interface_version
);

  // ==========================================================
  // Address decode, shared by the write and read paths
  function automatic logic hit(input slpr_pkg::slpr_addr_t a, input slpr_pkg::slpr_addr_t off);
    hit = (a == off);
  endfunction : hit

  // Writes land only while the core is parked, so a live link never sees a torn setting
  logic wr_ok;
  assign wr_ok = reg_wr && link_soft_reset;

  // ==========================================================
  // Writable settings
  logic       next_descramble_enable;
  logic [4:0] next_frames_per_multiframe_m1;
  logic [2:0] next_device_subclass;
  logic [2:0] next_interface_version;

  // One address per cycle, so the order of the chain never hides a second write
  // Next values; unsupported codes are dropped and the old setting kept
  always_comb begin
    next_descramble_enable        = descramble_enable;
    next_frames_per_multiframe_m1 = frames_per_multiframe_m1;
    next_device_subclass          = device_subclass;
    next_interface_version        = interface_version;
    if (wr_ok && hit(reg_addr, `SLPR_ADDR_DESCRAMBLE_LANE_COUNT)) begin
      next_descramble_enable = reg_wdata[`SLPR_DESCRAMBLE_BIT];
    end else if (wr_ok && hit(reg_addr, `SLPR_ADDR_FRAMES_PER_MULTIFRAME)) begin
      next_frames_per_multiframe_m1 = reg_wdata[`SLPR_LOW_FIELD_MSB:0];
    end else if (wr_ok && hit(reg_addr, `SLPR_ADDR_SUBCLASS_SAMPLE_WIDTH)) begin
      if (reg_wdata[`SLPR_UPPER_FIELD_MSB:`SLPR_UPPER_FIELD_LSB] == `SLPR_SUBCLASS_0 ||
          reg_wdata[`SLPR_UPPER_FIELD_MSB:`SLPR_UPPER_FIELD_LSB] == `SLPR_SUBCLASS_1) begin
        next_device_subclass = reg_wdata[`SLPR_UPPER_FIELD_MSB:`SLPR_UPPER_FIELD_LSB];
      end
    end else if (wr_ok && hit(reg_addr, `SLPR_ADDR_VERSION_SAMPLES)) begin
      if (reg_wdata[`SLPR_UPPER_FIELD_MSB:`SLPR_UPPER_FIELD_LSB] == `SLPR_VERSION_A ||
          reg_wdata[`SLPR_UPPER_FIELD_MSB:`SLPR_UPPER_FIELD_LSB] == `SLPR_VERSION_B) begin
        next_interface_version = reg_wdata[`SLPR_UPPER_FIELD_MSB:`SLPR_UPPER_FIELD_LSB];
      end
    end
  end

  // Reset values are the ones the link core expects before anyone writes
  // Register the settings
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      descramble_enable        <= `SLPR_RST_DESCRAMBLE;
      frames_per_multiframe_m1 <= `SLPR_RST_FRAMES_M1;
      device_subclass          <= `SLPR_RST_SUBCLASS;
      interface_version        <= `SLPR_RST_VERSION;
    end else begin
      descramble_enable        <= next_descramble_enable;
      frames_per_multiframe_m1 <= next_frames_per_multiframe_m1;
      device_subclass          <= next_device_subclass;
      interface_version        <= next_interface_version;
    end
  end

  // ==========================================================
  // Read path
  logic                 next_reg_rvalid;
  slpr_pkg::slpr_byte_t next_reg_rdata;

  // A read beside a write answers the old value; the write lands at that same edge
  // Read mux; fixed fields are constants, so the octet count can never steer the core
  always_comb begin
    next_reg_rvalid = reg_rd;
    next_reg_rdata  = 8'h00; // Unmapped and reserved read zero
    if (!reg_rd) begin
      next_reg_rdata = 8'h00;
    end else if (hit(reg_addr, `SLPR_ADDR_DESCRAMBLE_LANE_COUNT)) begin
      next_reg_rdata = {descramble_enable, 2'h0, `SLPR_LANE_COUNT_M1};
    end else if (hit(reg_addr, `SLPR_ADDR_OCTETS_PER_FRAME)) begin
      next_reg_rdata = `SLPR_OCTETS_M1;
    end else if (hit(reg_addr, `SLPR_ADDR_FRAMES_PER_MULTIFRAME)) begin
      next_reg_rdata = {3'h0, frames_per_multiframe_m1};
    end else if (hit(reg_addr, `SLPR_ADDR_CONVERTERS_PER_DEVICE)) begin
      next_reg_rdata = `SLPR_CONVERTERS_M1;
    end else if (hit(reg_addr, `SLPR_ADDR_CONTROL_BITS_RES)) begin
      next_reg_rdata = {`SLPR_CONTROL_BITS, 1'h0, `SLPR_RESOLUTION_M1};
    end else if (hit(reg_addr, `SLPR_ADDR_SUBCLASS_SAMPLE_WIDTH)) begin
      next_reg_rdata = {device_subclass, `SLPR_SAMPLE_BITS_M1};
    end else if (hit(reg_addr, `SLPR_ADDR_VERSION_SAMPLES)) begin
      next_reg_rdata = {interface_version, `SLPR_SAMPLES_M1};
    end
  end

  // Zero between answers, so a stale byte can never pass for a fresh one
  // Register the read answer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rvalid <= 1'b0;
      reg_rdata  <= 8'h00;
    end else begin
      reg_rvalid <= next_reg_rvalid;
      reg_rdata  <= next_reg_rdata;
    end
  end

  // ==========================================================
  // Checks
  a_descr_write_lands: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_ok && reg_addr == `SLPR_ADDR_DESCRAMBLE_LANE_COUNT) |=> descramble_enable == $past(reg_wdata[7]))
    else $error("descramble enable did not follow write");
  a_live_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !link_soft_reset |=> $stable({descramble_enable, frames_per_multiframe_m1, device_subclass, interface_version}))
    else $error("setting changed outside soft reset");
  a_lane_readback: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == `SLPR_ADDR_DESCRAMBLE_LANE_COUNT) |=> reg_rvalid && reg_rdata[6:0] == 7'h07)
    else $error("lane count readback wrong");
  a_octet_readback: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == `SLPR_ADDR_OCTETS_PER_FRAME) |=> reg_rdata == 8'h00)
    else $error("octet count readback wrong");
  a_frames_readback: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == `SLPR_ADDR_FRAMES_PER_MULTIFRAME) |=> reg_rdata == {3'h0, $past(frames_per_multiframe_m1)})
    else $error("frames per multiframe readback wrong");
  a_conv_readback: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == `SLPR_ADDR_CONVERTERS_PER_DEVICE) |=> reg_rdata == 8'h01)
    else $error("converter count readback wrong");
  a_ctrl_res_readback: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == `SLPR_ADDR_CONTROL_BITS_RES) |=> reg_rdata == 8'h0F)
    else $error("control bits or resolution readback wrong");
  a_subclass_legal: assert property (@(posedge clk) disable iff (!arst_n)
    device_subclass == 3'h0 || device_subclass == 3'h1)
    else $error("unsupported subclass selected");
  a_np_readback: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == `SLPR_ADDR_SUBCLASS_SAMPLE_WIDTH) |=> reg_rdata == {$past(device_subclass), 5'h0F})
    else $error("sample width readback wrong");
  a_version_legal: assert property (@(posedge clk) disable iff (!arst_n)
    interface_version == 3'h0 || interface_version == 3'h1)
    else $error("unsupported interface version held");
  a_samples_readback: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == `SLPR_ADDR_VERSION_SAMPLES) |=> reg_rdata == {$past(interface_version), 5'h01})
    else $error("samples per frame readback wrong");
  a_idle_zero: assert property (@(posedge clk) disable iff (!arst_n)
    !reg_rd |=> !reg_rvalid && reg_rdata == 8'h00)
    else $error("read data not zero when idle");

  // ==========================================================
  // Checks on the write path; a write to another address must leave descramble enable and frames per multiframe alone
  a_frames_write_lands: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_ok && reg_addr == `SLPR_ADDR_FRAMES_PER_MULTIFRAME) |=>
      frames_per_multiframe_m1 == $past(reg_wdata[4:0]))
    else $error("frames per multiframe did not follow write");
  a_descr_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_wr && reg_addr != `SLPR_ADDR_DESCRAMBLE_LANE_COUNT) |=> $stable(descramble_enable))
    else $error("descramble enable moved on a foreign write");
  a_frames_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_wr && reg_addr != `SLPR_ADDR_FRAMES_PER_MULTIFRAME) |=> $stable(frames_per_multiframe_m1))
    else $error("frames per multiframe moved on a foreign write");
  a_subclass_lands: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_ok && reg_addr == `SLPR_ADDR_SUBCLASS_SAMPLE_WIDTH && reg_wdata[7:5] <= 3'h1) |=>
      device_subclass == $past(reg_wdata[7:5]))
    else $error("supported subclass write dropped");
  a_subclass_refused: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_ok && reg_addr == `SLPR_ADDR_SUBCLASS_SAMPLE_WIDTH && reg_wdata[7:5] > 3'h1) |=>
      $stable(device_subclass))
    else $error("unsupported subclass write taken");
  a_version_lands: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_ok && reg_addr == `SLPR_ADDR_VERSION_SAMPLES && reg_wdata[7:5] <= 3'h1) |=>
      interface_version == $past(reg_wdata[7:5]))
    else $error("supported version write dropped");
  a_version_refused: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_ok && reg_addr == `SLPR_ADDR_VERSION_SAMPLES && reg_wdata[7:5] > 3'h1) |=>
      $stable(interface_version))
    else $error("unsupported version write taken");

  // ==========================================================
  // Checks on the read path; reserved and fixed bits must never leak state
  a_descr_readback: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == `SLPR_ADDR_DESCRAMBLE_LANE_COUNT) |=> reg_rdata[7] == $past(descramble_enable))
    else $error("descramble enable readback wrong");
  a_lane_reserved: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == `SLPR_ADDR_DESCRAMBLE_LANE_COUNT) |=> reg_rdata[6:5] == 2'h0)
    else $error("reserved lane bits not zero");
  a_ctrl_bits_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == `SLPR_ADDR_CONTROL_BITS_RES) |=> reg_rdata[7:6] == 2'h0)
    else $error("control bits per sample not zero");
  a_res_readback: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == `SLPR_ADDR_CONTROL_BITS_RES) |=> reg_rdata[4:0] == 5'h0F)
    else $error("converter resolution readback wrong");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_rd && (reg_addr < `SLPR_ADDR_DESCRAMBLE_LANE_COUNT || reg_addr > `SLPR_ADDR_VERSION_SAMPLES)) |=>
      reg_rvalid && reg_rdata == 8'h00)
    else $error("unmapped address did not read zero");

endmodule : slpr_regs

// ### bench/slpr_link_model.sv
// Link core side model: soft reset hold and watch of the settings it receives
`timescale 1ns/1ps
module slpr_link_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Control from the bench
  input  wire logic       hold_req,
  // Settings from the bank
  input  wire logic       descramble_enable,
  input  wire logic [4:0] frames_per_multiframe_m1,
  input  wire logic [2:0] device_subclass,
  input  wire logic [2:0] interface_version,
  // Towards the bank and the bench
  output logic            link_soft_reset,
  output logic            settings_bad
);
  logic       next_link_soft_reset;
  logic [8:0] held;
  // ==========================================================
  // Soft reset follows the bench request one cycle later
  always_comb next_link_soft_reset = hold_req;
  // Settings must stay put while the core runs; subclass 2 is never accepted
  // A change seen now was made at the last edge, so it is judged by the soft reset held before it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link_soft_reset <= 1'b0;
      settings_bad    <= 1'b0;
      held            <= {1'b1, 5'h1F, 3'h0}; // Settings at reset, soft reset low
    end else begin
      link_soft_reset <= next_link_soft_reset;
      held            <= {descramble_enable, frames_per_multiframe_m1, device_subclass[0], interface_version[0],
                          link_soft_reset};
      if (device_subclass > 3'h1 || interface_version > 3'h1) begin
        settings_bad <= 1'b1;
      end
      if (!held[0] && held[8:1] !=
          {descramble_enable, frames_per_multiframe_m1, device_subclass[0], interface_version[0]}) begin
        settings_bad <= 1'b1;
      end
    end
  end
endmodule : slpr_link_model

// ### bench/slpr_regs_test.sv
// Self-checking bench of the link parameter bank
`timescale 1ns/1ps
module slpr_regs_test;
  typedef struct {logic [11:0] addr; int wr; logic [7:0] wdata; logic [7:0] exp;} slpr_row_s;
  logic clk, arst_n, reg_wr, reg_rd, reg_rvalid, link_soft_reset, hold_req, settings_bad;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, csum, got;
  logic        descramble_enable;
  logic [4:0]  frames_per_multiframe_m1;
  logic [2:0]  device_subclass, interface_version;
  int          n_errors, compares, i;
  slpr_row_s   rows [20];
  slpr_regs dut_u (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata), .link_soft_reset(link_soft_reset),
    .descramble_enable(descramble_enable), .frames_per_multiframe_m1(frames_per_multiframe_m1),
    .device_subclass(device_subclass), .interface_version(interface_version));
  slpr_link_model link_u (.clk(clk), .arst_n(arst_n), .hold_req(hold_req), .descramble_enable(descramble_enable),
    .frames_per_multiframe_m1(frames_per_multiframe_m1), .device_subclass(device_subclass),
    .interface_version(interface_version), .link_soft_reset(link_soft_reset), .settings_bad(settings_bad));
  // ==========================================================
  // Clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_wr <= 1'b0;
  endtask : wr_reg
  // Answer is fixed one cycle after the request edge, so no wait loop is needed
  task automatic rd_get(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    #1;
    chk({7'h00, reg_rvalid}, 8'h01, "read answer");
    d = reg_rdata;
  endtask : rd_get
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_get(a, d);
    chk(d, exp, "read data");
  endtask : rd_chk
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  // ==========================================================
  // Main sequence
  initial begin
    {arst_n, reg_wr, reg_rd, hold_req, reg_addr, reg_wdata} = '0;
    n_errors = 0;
    compares = 0;
    rows = '{'{12'h453, 0, 8'h00, 8'h87}, '{12'h454, 0, 8'h00, 8'h00}, '{12'h455, 0, 8'h00, 8'h1F},
      '{12'h456, 0, 8'h00, 8'h01}, '{12'h457, 0, 8'h00, 8'h0F}, '{12'h458, 0, 8'h00, 8'h0F},
      '{12'h459, 0, 8'h00, 8'h01}, '{12'h45A, 0, 8'h00, 8'h00}, '{12'h452, 0, 8'h00, 8'h00},
      '{12'h455, 1, 8'h0F, 8'h1F}, '{12'h000, 0, 8'h00, 8'h00}, '{12'h455, 1, 8'hEF, 8'h0F},
      '{12'h453, 1, 8'h7F, 8'h07}, '{12'h458, 1, 8'h2F, 8'h2F}, '{12'h458, 1, 8'h4F, 8'h2F},
      '{12'h459, 1, 8'h20, 8'h21}, '{12'h454, 1, 8'hFF, 8'h00}, '{12'h456, 1, 8'hFF, 8'h01},
      '{12'h457, 1, 8'hFF, 8'h0F}, '{12'h458, 1, 8'h0F, 8'h0F}};
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    // Row 10 enters soft reset; earlier writes must be dropped
    for (i = 0; i < 20; i++) begin
      if (i == 10) begin
        @(posedge clk) hold_req <= 1'b1;
        repeat (2) @(posedge clk);
      end else begin
        if (rows[i].wr) wr_reg(rows[i].addr, rows[i].wdata);
        rd_chk(rows[i].addr, rows[i].exp);
      end
      if (i == 16) begin
        chk({descramble_enable, 2'h0, frames_per_multiframe_m1}, 8'h0F, "core settings");
        chk({2'h0, device_subclass, interface_version}, 8'h09, "subclass and version");
      end
    end
    $display("test table done");
    // Two writes one idle cycle apart with the core running must be dropped
    @(posedge clk) hold_req <= 1'b0;
    repeat (2) @(posedge clk);
    wr_reg(12'h455, 8'h03);
    wr_reg(12'h453, 8'h80);
    rd_chk(12'h455, 8'h0F);
    rd_chk(12'h453, 8'h07);
    chk({7'h00, settings_bad}, 8'h00, "settings moved");
    $display("test running core done");
    // Mid-run reset restores every setting
    @(posedge clk) arst_n <= 1'b0;
    #1;
    chk({descramble_enable, 2'h0, frames_per_multiframe_m1}, 8'h9F, "reset settings");
    chk({2'h0, device_subclass, interface_version}, 8'h00, "reset codes");
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rd_chk(12'h459, 8'h01);
    $display("test reset done");
    // Host side checksum over the whole parameter span; neighbours outside this bank read zero here
    csum = 8'h00;
    for (i = 'h450; i <= 'h45C; i++) begin
      rd_get(i[11:0], got);
      csum += got;
    end
    chk(csum, 8'hC6, "checksum of reset values");
    $display("test checksum done");
    // Read beside a write on one edge answers the old value; the new one lands at that edge
    @(posedge clk) hold_req <= 1'b1;
    repeat (2) @(posedge clk);
    @(posedge clk) {reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'h3, 12'h459, 8'h3F};
    @(posedge clk) {reg_wr, reg_rd} <= 2'h0;
    #1;
    chk({7'h00, reg_rvalid}, 8'h01, "answer beside write");
    chk(reg_rdata, 8'h01, "read beside write");
    @(posedge clk);
    #1;
    chk({7'h00, reg_rvalid}, 8'h00, "answer stands one cycle");
    chk(reg_rdata, 8'h00, "idle read data");
    rd_chk(12'h459, 8'h21);
    wr_reg(12'h459, 8'h5F);
    rd_chk(12'h459, 8'h21);
    chk({7'h00, settings_bad}, 8'h00, "settings moved");
    $display("test read beside write done");
    conclude();
  end
endmodule : slpr_regs_test
